// [verilog/ctc_pkg.sv]
// constants for the counter/timer channel: control word fields, values
// after reset, prescaler terminal counts and the channel state encoding.
// assumes nothing of its surroundings; every use is ctc_pkg::name.
package ctc_pkg;

  // ****************************************************************
  // control word bit positions
  // ****************************************************************
  localparam int CTRL_FLAG_BIT = 0;
  localparam int SOFT_RESET_BIT = 1;
  localparam int TC_FOLLOWS_BIT = 2;
  localparam int TRIG_START_BIT = 3;
  localparam int EDGE_RISING_BIT = 4;
  localparam int PRESCALE_256_BIT = 5;
  localparam int COUNTER_MODE_BIT = 6;
  localparam int INT_ENABLE_BIT = 7;

  // ****************************************************************
  // vector byte layout
  // ****************************************************************
  localparam int VEC_HI_LSB = 3;
  localparam int VEC_CH_LSB = 1;

  // ****************************************************************
  // counts and values after reset
  // ****************************************************************
  localparam logic [7:0] PRE_LAST_16 = 8'h0F;
  localparam logic [7:0] PRE_LAST_256 = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TC_RESET = 8'h00;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [4:0] VEC_HI_RESET = 5'h00;
  // enabled edges before the synchroniser's third stage holds a pin sample
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // gray coded along idle -> wait for trigger -> counting
  typedef enum logic [1:0] {
    ST_HALTED = 2'b00,
    ST_WAIT_TRIG = 2'b01,
    ST_COUNTING = 2'b11
  } chan_state_e;

endpackage

// [verilog/edge_if.sv]
// edge events of the count/trigger pin, carried from the synchroniser
// to the channel logic. assumes both ends share one clock.
`timescale 1ns/100ps

interface edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

// [verilog/pin_edge_sync.sv]
// three-stage synchroniser with edge detection for an asynchronous pin.
// assumes a free running clock; clk_en low freezes every stage.
`timescale 1ns/100ps

module pin_edge_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic pin,
  edge_if.src ev
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic primed;
    logic [1:0] fill;
    logic rise;
    logic fall;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // ****************************************************************
  // a change counts once the second and third stages agree
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    // stages hold reset zeros until filled; learning the idle level
    // from them would report a false edge on a pin that idles high
    if (st.fill != ctc_pkg::SYNC_FILL) begin
      next_st.fill = st.fill + 2'h1;
    end
    if (st.s2 == st.s3 && st.fill == ctc_pkg::SYNC_FILL) begin
      // first agreement only learns the idle level, so no false edge
      if (!st.primed) begin
        next_st.primed = 1'b1;
        next_st.level = st.s3;
      end else if (st.s3 != st.level) begin
        next_st.level = st.s3;
        next_st.rise = st.s3;
        next_st.fall = !st.s3;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign ev.rise = st.rise;
  assign ev.fall = st.fall;

endmodule

// [verilog/counter_timer_channel.sv]
// one 8-bit counter/timer channel written through a single byte port.
// assumes port writes are one-cycle strobes on clk and the pin is async.
//
// Overview of operation
// [R1] a port byte with bit 0 set is taken as the channel control word.
// [R2] control bit 7 enables an interrupt request at every zero count.
// [R3] interrupts work in both modes and bit 7 may change at any time.
// [R4] bit 6 picks timer mode (prescaled clock) or counter mode (pin edges).
// [R5] in timer mode bit 5 picks a prescaler of 16 or 256.
// [R6] bit 4 picks the rising or the falling pin edge as active.
// [R7] bit 3 picks automatic timer start or start on an active pin edge.
// [R8] a control word with bit 2 set makes the next byte the time constant.
// [R9] a control word with bit 1 set halts counting until a new constant.
// [R10] nothing counts until a time constant has been written.
// [R11] the constant gives counts of 1 to 256, with zero meaning 256.
// [R12] a byte with bit 0 clear sets the upper five vector bits; the
//       channel number fills bits 2 to 1 of the returned vector; the code returns 0 there from reset until the first enabled clock.
// [R13] at zero count the counter reloads the constant and keeps going.
`timescale 1ns/100ps

module counter_timer_channel #(
  parameter logic [1:0] CHANNEL_NUM = 2'h0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic port_wr,
  input wire logic [7:0] port_data,
  input wire logic count_trigger_input,
  input wire logic int_ack,
  output logic int_req,
  output logic zero_count,
  output logic counting,
  output logic [7:0] int_vector,
  output logic [7:0] count_value
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] tc;
    logic [7:0] count;
    logic [7:0] pre;
    logic tc_next;
    logic reload_pend;
    ctc_pkg::chan_state_e state;
    logic int_pend;
    logic zc;
    logic run;
    logic [4:0] vec_hi;
    logic [7:0] vec;
    logic [7:0] cnt_out;
  } chan_s;

  chan_s st;
  chan_s next_st;

  edge_if pin_ev ();

  pin_edge_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin(count_trigger_input),
    .ev(pin_ev)
  );

  // ****************************************************************
  // decoded control fields
  // ****************************************************************
  logic ctrl_write;
  logic tc_write;
  logic vec_write;
  logic active_edge;
  logic pre_last;
  logic tick;
  logic hits_zero;
  logic [7:0] pre_limit;

  always_comb begin
    ctrl_write = port_wr && !st.tc_next
      && port_data[ctc_pkg::CTRL_FLAG_BIT]; // [R1]
    tc_write = port_wr && st.tc_next; // [R8]
    vec_write = port_wr && !st.tc_next
      && !port_data[ctc_pkg::CTRL_FLAG_BIT]; // [R12]
    active_edge = st.ctrl[ctc_pkg::EDGE_RISING_BIT]
      ? pin_ev.rise : pin_ev.fall; // [R6]
    pre_limit = st.ctrl[ctc_pkg::PRESCALE_256_BIT]
      ? ctc_pkg::PRE_LAST_256 : ctc_pkg::PRE_LAST_16; // [R5]
    pre_last = (st.pre == pre_limit);
    if (st.state != ctc_pkg::ST_COUNTING) begin
      tick = 1'b0;
    end else if (st.ctrl[ctc_pkg::COUNTER_MODE_BIT]) begin
      tick = active_edge; // [R4]
    end else begin
      tick = pre_last; // [R4]
    end
    // count 0 stands for 256, so zero is reached from a count of one
    hits_zero = tick && (st.count == ctc_pkg::COUNT_ONE); // [R11]
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.zc = 1'b0;

    // prescaler runs only while the timer is counting
    if (st.state == ctc_pkg::ST_COUNTING
        && !st.ctrl[ctc_pkg::COUNTER_MODE_BIT]) begin
      next_st.pre = pre_last ? ctc_pkg::PRE_RESET : st.pre + 8'h01;
    end else begin
      next_st.pre = ctc_pkg::PRE_RESET;
    end

    // waiting timer starts on the selected pin edge
    if (st.state == ctc_pkg::ST_WAIT_TRIG && active_edge) begin
      next_st.state = ctc_pkg::ST_COUNTING; // [R7]
    end

    if (tick) begin
      if (hits_zero) begin
        next_st.count = st.tc; // [R13]
        next_st.reload_pend = 1'b0;
        next_st.zc = 1'b1;
        if (st.ctrl[ctc_pkg::INT_ENABLE_BIT]) begin
          next_st.int_pend = 1'b1; // [R2]
        end
      end else begin
        next_st.count = st.count - 8'h01;
      end
    end

    if (ctrl_write) begin
      next_st.ctrl = port_data; // [R3]
      next_st.tc_next = port_data[ctc_pkg::TC_FOLLOWS_BIT]; // [R8]
      if (port_data[ctc_pkg::SOFT_RESET_BIT]) begin
        next_st.state = ctc_pkg::ST_HALTED; // [R9]
        next_st.pre = ctc_pkg::PRE_RESET;
      end
      // clearing the enable in a cycle without a zero count withdraws a request not yet served
      if (!port_data[ctc_pkg::INT_ENABLE_BIT] && !hits_zero) begin
        next_st.int_pend = 1'b0; // [R3]
      end
    end

    if (tc_write) begin
      next_st.tc = port_data;
      next_st.tc_next = 1'b0;
      if (st.state == ctc_pkg::ST_HALTED) begin
        // start only from a halted channel with a constant in hand
        next_st.count = port_data; // [R10]
        next_st.pre = ctc_pkg::PRE_RESET;
        if (!st.ctrl[ctc_pkg::COUNTER_MODE_BIT]
            && st.ctrl[ctc_pkg::TRIG_START_BIT]) begin
          next_st.state = ctc_pkg::ST_WAIT_TRIG; // [R7]
        end else begin
          next_st.state = ctc_pkg::ST_COUNTING; // [R7]
        end
      end else begin
        // a running channel takes the new constant at its next reload
        next_st.reload_pend = 1'b1; // [R13]
      end
    end

    if (vec_write) begin
      next_st.vec_hi = port_data[7:ctc_pkg::VEC_HI_LSB]; // [R12]
    end

    // a zero count in the acknowledge cycle keeps its request
    if (int_ack && !(hits_zero && st.ctrl[ctc_pkg::INT_ENABLE_BIT])) begin
      next_st.int_pend = 1'b0; // [R2]
    end

    next_st.run = (next_st.state == ctc_pkg::ST_COUNTING);
    next_st.vec = {next_st.vec_hi, CHANNEL_NUM, 1'b0}; // [R12]
    next_st.cnt_out = next_st.count;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.ctrl <= ctc_pkg::CTRL_RESET;
      st.tc <= ctc_pkg::TC_RESET;
      st.count <= ctc_pkg::TC_RESET;
      st.pre <= ctc_pkg::PRE_RESET;
      st.tc_next <= 1'b0;
      st.reload_pend <= 1'b0;
      st.state <= ctc_pkg::ST_HALTED; // [R10]
      st.int_pend <= 1'b0;
      st.zc <= 1'b0;
      st.run <= 1'b0;
      st.vec_hi <= ctc_pkg::VEC_HI_RESET;
      st.vec <= {ctc_pkg::VEC_HI_RESET, 2'h0, 1'b0};
      st.cnt_out <= ctc_pkg::TC_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign int_req = st.int_pend;
  assign zero_count = st.zc;
  assign counting = st.run;
  assign int_vector = st.vec;
  assign count_value = st.cnt_out;

endmodule

// [verif/ctc_properties.sv]
// port assertions for the channel, bound into every channel instance.
// assumes one clock domain and single-cycle port write strobes.
`timescale 1ns/100ps
module ctc_properties #(
  parameter logic [1:0] CHANNEL_NUM = 2'h0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic port_wr,
  input wire logic [7:0] port_data,
  input wire logic count_trigger_input,
  input wire logic int_ack,
  input wire logic int_req,
  input wire logic zero_count,
  input wire logic counting,
  input wire logic [7:0] int_vector,
  input wire logic [7:0] count_value
);
  // ****************************************************************
  // shadow of the port decoding
  // ****************************************************************
  logic tcp, ie, armed;
  logic [7:0] tcs;
  wire logic wr = port_wr && clk_en;
  wire logic cw = wr && !tcp && port_data[0];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tcp <= 1'b0;
      ie <= 1'b0;
      armed <= 1'b0;
      tcs <= 8'h00;
    end else if (wr) begin
      tcp <= cw && port_data[2];
      ie <= cw ? port_data[7] : ie;
      armed <= tcp || (armed && !(cw && port_data[1]));
      tcs <= tcp ? port_data : tcs;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_halt;
    cw && port_data[1];
  endsequence
  sequence s_vec;
    wr && !tcp && !port_data[0];
  endsequence
  property p_halt;
    s_halt |=> !counting;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_vec;
    s_vec |=> int_vector == {$past(port_data[7:3]), CHANNEL_NUM, 1'b0};
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_quiet;
    !armed |-> !counting;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_reload;
    zero_count |-> count_value == tcs;
  endproperty
  a_reload: assert property (p_reload) else $error("reload");
  property p_irq;
    zero_count && $past(ie) && $past(clk_en) |-> int_req;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_irqsrc;
    $rose(int_req) |-> zero_count;
  endproperty
  a_irqsrc: assert property (p_irqsrc) else $error("irq source");
  property p_ack;
    int_ack && clk_en |=> !int_req || zero_count;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_pulse;
    zero_count |=> !zero_count || !$past(clk_en);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
endmodule

bind counter_timer_channel ctc_properties #(.CHANNEL_NUM(CHANNEL_NUM)) p (
  .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .port_wr(port_wr),
  .port_data(port_data), .count_trigger_input(count_trigger_input),
  .int_ack(int_ack), .int_req(int_req), .zero_count(zero_count),
  .counting(counting), .int_vector(int_vector), .count_value(count_value)
);

// [verif/pin_source.sv]
// pulse source for the count/trigger pin, one high pulse per request.
// assumes requests come at least 12 clocks apart.
`timescale 1ns/100ps
module pin_source (
  input wire logic clk,
  input wire logic fire,
  output logic pin
);
  // ****************************************************************
  // pulse of 8 clocks, well above the synchroniser's minimum width
  // ****************************************************************
  logic [3:0] left;
  initial pin = 1'b0;
  initial left = 4'h0;
  always @(posedge clk) begin
    if (fire)
      left <= 4'h8;
    else if (left != 4'h0)
      left <= left - 4'h1;
    pin <= fire || left > 4'h1;
  end
endmodule

// [verif/tb.sv]
// self-checking bench: one channel, a pulse source on its pin.
// assumes the channel, pin_source and the bound checker are compiled.
`timescale 1ns/100ps
module tb;
  logic clk, arst_n, clk_en, port_wr, int_ack, fire, pin;
  logic int_req, zero_count, counting;
  logic [7:0] port_data, int_vector, count_value, v, n;
  logic [31:0] cyc, ref_cyc, seed;
  logic [24:0] q[$];
  logic [24:0] e;
  int errors, check_count;
  counter_timer_channel #(.CHANNEL_NUM(2'h2)) dut (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .port_wr(port_wr),
    .port_data(port_data), .count_trigger_input(pin), .int_ack(int_ack),
    .int_req(int_req), .zero_count(zero_count), .counting(counting),
    .int_vector(int_vector), .count_value(count_value)
  );
  pin_source src (.clk(clk), .fire(fire), .pin(pin));
  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, x, s);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr1(input logic [7:0] d, input logic en);
    clk_en <= en;
    port_data <= d;
    port_wr <= 1'b1;
    @(posedge clk);
    clk_en <= 1'b1;
    port_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic prog(input logic [7:0] c, t);
    port_data <= c;
    port_wr <= 1'b1;
    @(posedge clk);
    port_data <= t;
    ref_cyc = cyc;
    @(posedge clk);
    port_wr <= 1'b0;
  endtask
  task automatic pulse();
    fire <= 1'b1;
    ref_cyc = cyc + 32'h1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // halting word also drops any pending request
  task automatic drain();
    while (q.size() != 0) @(posedge clk);
    int_ack <= 1'b1;
    @(posedge clk);
    int_ack <= 1'b0;
    wr1(8'h03, 1'b1);
    check("counting", {31'h0, counting}, 32'h0);
    repeat (16) @(posedge clk);
  endtask
  task automatic run(input logic [7:0] c, t, input logic [15:0] d1, d2);
    prog(c, t);
    q.push_back({d1, c[7], t});
    q.push_back({d2, c[7], t});
    drain();
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (cyc > 32'h4E20) begin
      errors++;
      complete_run();
    end
    if (zero_count === 1'b1) begin
      e = (q.size() != 0) ? q.pop_front() : 25'h1FFFFFF;
      if (e[24:9] != 16'h0)
        check("gap", cyc - ref_cyc, {16'h0, e[24:9]});
      check("zero", {int_req, count_value}, e[8:0]);
      ref_cyc = cyc;
    end
  end
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    port_wr = 1'b0;
    port_data = 8'h00;
    int_ack = 1'b0;
    fire = 1'b0;
    cyc = 32'h0;
    ref_cyc = 32'h0;
    errors = 0;
    check_count = 0;
    seed = $urandom(32'h03CE);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("vector", {24'h0, int_vector}, 32'h04);
    check("counting", {31'h0, counting}, 32'h0);
    v = $urandom;
    wr1(v & 8'hFE, 1'b0);
    check("vector", {24'h0, int_vector}, 32'h04);
    wr1(v & 8'hFE, 1'b1);
    check("vector", {24'h0, int_vector}, {24'h0, v[7:3], 3'h4});
    n = 8'h01 + 8'($urandom % 4);
    run(8'h07, n, {4'h0, n, 4'h2}, {4'h0, n, 4'h0});
    run(8'h87, 8'h00, 16'h1002, 16'h1000);
    run(8'hA7, 8'h01, 16'h0102, 16'h0100);
    prog(8'h9F, 8'h01);
    repeat (8) @(posedge clk);
    check("counting", {31'h0, counting}, 32'h0);
    q.push_back({16'h0, 1'b1, 8'h01});
    q.push_back({16'h10, 1'b1, 8'h01});
    pulse();
    drain();
    for (int i = 0; i < 2; i++) begin
      prog(i ? 8'hC7 : 8'hD7, 8'h01);
      q.push_back({i ? 16'hE : 16'h6, 1'b1, 8'h01});
      pulse();
      drain();
    end
    check("pending", q.size(), 32'h0);
    complete_run();
  end
endmodule
